// ---- asp_pkg.sv ----
/*
 Shared constants and types for the audio serial port transmit framing block.
 Assumes the importing logic keeps every bit-clock position in asp_pos_t.
*/
`default_nettype none
package asp_pkg;
   // Serial formats of the data output
   typedef enum logic [1:0] {ASP_FMT_I2S, ASP_FMT_DSP, ASP_FMT_RJF, ASP_FMT_LJF} asp_fmt_t;

   localparam int ASP_SAMPLE_W = 32;
   localparam int ASP_POS_W = 10;
   localparam int ASP_DELAY_W = 8;
   typedef logic [ASP_POS_W-1:0] asp_pos_t;

   // Word length codes
   localparam logic [1:0] ASP_WL_16 = 2'h0;
   localparam logic [1:0] ASP_WL_20 = 2'h1;
   localparam logic [1:0] ASP_WL_24 = 2'h2;
   localparam logic [1:0] ASP_WL_32 = 2'h3;
   localparam asp_pos_t ASP_LEN_16 = 10'h010;
   localparam asp_pos_t ASP_LEN_20 = 10'h014;
   localparam asp_pos_t ASP_LEN_24 = 10'h018;
   localparam asp_pos_t ASP_LEN_32 = 10'h020;

   // Position counting: first bit-clock rising edge after a word-clock rise is 1
   localparam asp_pos_t ASP_POS_FIRST = 10'h001;
   localparam asp_pos_t ASP_I2S_EXTRA = 10'h001;
   // Frame shape assumed until the first word-clock rise and fall after reset
   localparam asp_pos_t ASP_FLEN_RST = 10'h040;
   localparam asp_pos_t ASP_FPOS_RST = 10'h021;

   typedef struct packed {
      asp_fmt_t fmt;
      logic [1:0] wl;
      logic [ASP_DELAY_W-1:0] first_slot_delay;
      logic [ASP_DELAY_W-1:0] second_slot_delay;
      logic swap;
      logic slot_mode;
      logic first_off;
      logic second_off;
      logic hiz;
      logic hiz_early;
   } asp_cfg_t;
endpackage
`default_nettype wire

// ---- asp_framing.sv ----
/*
 Transmit framing of a stereo audio serial data port: places left and right samples
 on the data pin against the word and bit clocks in I2S, DSP, left- and
 right-justified formats, with slot offsets, slot mode, swap and three-state control.
 Assumes word and bit clocks come from outside, word clock changing on bit-clock
 falling edges, and that bclk_invert_i is static while the link runs.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_framing
   import asp_pkg::*;
(
   // System clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Configuration, taken together with each sample pair except bclk_invert_i
   input wire asp_pkg::asp_fmt_t fmt_i,
   input wire logic [1:0] word_len_i,
   input wire logic [asp_pkg::ASP_DELAY_W-1:0] first_slot_delay_i,
   input wire logic [asp_pkg::ASP_DELAY_W-1:0] second_slot_delay_i,
   input wire logic chan_swap_i,
   input wire logic slot_mode_i,
   input wire logic first_chan_off_i,
   input wire logic second_chan_off_i,
   input wire logic dout_hiz_i,
   input wire logic dout_hiz_early_i,
   input wire logic bclk_invert_i,
   // Sample stream from the converter
   input wire logic [asp_pkg::ASP_SAMPLE_W-1:0] left_sample_i,
   input wire logic [asp_pkg::ASP_SAMPLE_W-1:0] right_sample_i,
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   output logic filter_sync_o,
   // Clock generator gating
   input wire logic clk_master_i,
   input wire logic conv_powered_i,
   input wire logic clk_keep_i,
   output logic clk_gen_run_o,
   // Serial link
   input wire logic bclk_i,
   input wire logic wclk_i,
   output logic dout_o,
   output logic dout_oe_n_o
);
   import asp_pkg::*;

   typedef struct packed {
      logic req;
      logic [1:0] ack_s;
      logic [2:0] syn_s;
      logic [2*ASP_SAMPLE_W-1:0] hold;
      asp_cfg_t cfg;
      logic run;
      logic sync_p;
   } asp_sys_t;

   typedef struct packed {
      logic [1:0] req_s;
      logic ack;
      logic [2*ASP_SAMPLE_W-1:0] words;
      asp_cfg_t cfg;
      logic wq;
      asp_pos_t pos;
      asp_pos_t flen;
      asp_pos_t fpos;
      logic pend;
      logic pend_oe_n;
      logic pend_lsb;
      logic cut;
      logic sync_t;
   } asp_link_t;

   typedef struct packed {
      logic d;
      logic oe_n;
      logic lsb;
   } asp_neg_t;

   asp_sys_t s, next_s;
   asp_link_t l, next_l;
   asp_neg_t nq;
   logic lclk;

   function automatic asp_pos_t wl_bits(input logic [1:0] code);
      unique case (code)
         ASP_WL_16: wl_bits = ASP_LEN_16;
         ASP_WL_20: wl_bits = ASP_LEN_20;
         ASP_WL_24: wl_bits = ASP_LEN_24;
         ASP_WL_32: wl_bits = ASP_LEN_32;
      endcase
   endfunction

   function automatic logic in_slot(input asp_pos_t t, input asp_pos_t st, input asp_pos_t wl);
      in_slot = (t >= st) && (t < asp_pos_t'(st + wl));
   endfunction

   // MSB first; shorter words sit in the low bits of the sample
   function automatic logic bit_at(input logic [ASP_SAMPLE_W-1:0] w, input asp_pos_t t,
                                   input asp_pos_t st, input asp_pos_t wl);
      asp_pos_t idx;
      idx = asp_pos_t'(wl - ASP_POS_FIRST - asp_pos_t'(t - st));
      bit_at = w[idx[4:0]];
   endfunction

   // System side: sample handshake, clock gating and filter sync pulse

   always_comb begin
      next_s = s;
      next_s.ack_s = {s.ack_s[0], l.ack};
      next_s.syn_s = {s.syn_s[1:0], l.sync_t};
      next_s.sync_p = s.syn_s[1] ^ s.syn_s[2];
      next_s.run = clk_master_i & (conv_powered_i | clk_keep_i);
      if (sample_valid_i && sample_ready_o) begin
         next_s.hold = {left_sample_i, right_sample_i};
         next_s.cfg.fmt = fmt_i;
         next_s.cfg.wl = word_len_i;
         next_s.cfg.first_slot_delay = first_slot_delay_i;
         next_s.cfg.second_slot_delay = second_slot_delay_i;
         next_s.cfg.swap = chan_swap_i;
         next_s.cfg.slot_mode = slot_mode_i;
         next_s.cfg.first_off = first_chan_off_i;
         next_s.cfg.second_off = second_chan_off_i;
         next_s.cfg.hiz = dout_hiz_i;
         next_s.cfg.hiz_early = dout_hiz_early_i;
         next_s.req = ~s.req;
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Hold stays put until the link acknowledges, so its words cross safely
   assign sample_ready_o = (s.req == s.ack_s[1]);
   assign filter_sync_o = s.sync_p;
   assign clk_gen_run_o = s.run;

   // Link side. Inverting in the clock path keeps all bit timing on one edge pair,
   // at the cost of a glitch if the invert bit moves while the bit clock runs.
   assign lclk = bclk_i ^ bclk_invert_i;

   always_comb begin
      logic rise;
      logic fall;
      logic dsp;
      logic rjf;
      logic ts;
      logic a_right;
      logic off_a;
      logic off_b;
      logic hit_a;
      logic hit_b;
      asp_pos_t np;
      asp_pos_t t;
      asp_pos_t wl;
      asp_pos_t extra;
      asp_pos_t sa;
      asp_pos_t sb;
      asp_pos_t sync_at;
      logic [ASP_SAMPLE_W-1:0] wa;
      logic [ASP_SAMPLE_W-1:0] wb;
      // Every local gets a value up front so no path can leave a latch behind
      rise = 1'b0;
      fall = 1'b0;
      dsp = 1'b0;
      rjf = 1'b0;
      ts = 1'b0;
      a_right = 1'b0;
      off_a = 1'b0;
      off_b = 1'b0;
      hit_a = 1'b0;
      hit_b = 1'b0;
      np = '0;
      t = '0;
      wl = '0;
      extra = '0;
      sa = '0;
      sb = '0;
      sync_at = '0;
      wa = '0;
      wb = '0;
      next_l = l;
      // Sample pair crossing: the request toggle has passed two link flops,
      // and the system side holds words and settings until the ack returns,
      // so they are stable when copied here
      next_l.req_s = {l.req_s[0], s.req};
      if (l.req_s[1] != l.ack) begin
         next_l.ack = l.req_s[1];
         next_l.words = s.hold;
         next_l.cfg = s.cfg;
      end
      // Word clock is launched by the far side on bit-clock falling edges,
      // so it is settled at every rising edge and needs no extra stage here
      next_l.wq = wclk_i;
      rise = wclk_i & ~l.wq;
      fall = ~wclk_i & l.wq;
      dsp = (l.cfg.fmt == ASP_FMT_DSP);
      rjf = (l.cfg.fmt == ASP_FMT_RJF);
      ts = l.cfg.slot_mode & ~rjf;
      // Position restarts at each word-clock rise; frame shape learnt from the last frame
      if (rise) begin
         np = ASP_POS_FIRST;
         next_l.flen = l.pos;
      end else begin
         np = asp_pos_t'(l.pos + ASP_POS_FIRST);
      end
      if (fall) begin
         next_l.fpos = np;
      end
      next_l.pos = np;
      // DSP data changes on the rising edge and is valid on the following falling edge;
      // other formats launch on the falling edge for the next rising edge
      if (dsp) begin
         t = np;
      end else if (np >= next_l.flen) begin
         t = ASP_POS_FIRST;
      end else begin
         t = asp_pos_t'(np + ASP_POS_FIRST);
      end
      // Slot a starts after the word-clock rise; slot b after the fall, after
      // slot a in slot mode or DSP, or at the frame end in right-justified
      wl = wl_bits(l.cfg.wl);
      extra = (l.cfg.fmt == ASP_FMT_I2S) ? ASP_I2S_EXTRA : '0;
      sa = asp_pos_t'(l.cfg.first_slot_delay + ASP_POS_FIRST + extra);
      if (rjf) begin
         sa = asp_pos_t'(next_l.fpos - wl);
         sb = asp_pos_t'(next_l.flen - wl + ASP_POS_FIRST);
      end else if (ts) begin
         sb = asp_pos_t'(sa + wl + l.cfg.second_slot_delay);
      end else if (dsp) begin
         sb = asp_pos_t'(sa + wl);
      end else begin
         sb = asp_pos_t'(next_l.fpos + l.cfg.first_slot_delay + extra);
      end
      // I2S places the left word after the fall, so its rise slot is right unless swapped
      a_right = l.cfg.swap ^ (l.cfg.fmt == ASP_FMT_I2S);
      wa = a_right ? l.words[ASP_SAMPLE_W-1:0] : l.words[2*ASP_SAMPLE_W-1:ASP_SAMPLE_W];
      wb = a_right ? l.words[2*ASP_SAMPLE_W-1:ASP_SAMPLE_W] : l.words[ASP_SAMPLE_W-1:0];
      off_a = l.cfg.first_off & ~rjf;
      off_b = l.cfg.second_off & ~rjf;
      hit_a = in_slot(t, sa, wl) & ~off_a;
      hit_b = in_slot(t, sb, wl) & ~off_b;
      if (hit_a) begin
         next_l.pend = bit_at(wa, t, sa, wl);
         next_l.pend_lsb = (t == asp_pos_t'(sa + wl - ASP_POS_FIRST));
      end else if (hit_b) begin
         next_l.pend = bit_at(wb, t, sb, wl);
         next_l.pend_lsb = (t == asp_pos_t'(sb + wl - ASP_POS_FIRST));
      end else begin
         next_l.pend = 1'b0;
         next_l.pend_lsb = 1'b0;
      end
      // Outside both slots the pin floats or is driven low, never left at data
      next_l.pend_oe_n = ~(hit_a | hit_b) & l.cfg.hiz;
      // Early release would need nq.lsb and l.pend_oe_n set for the same bit; an LSB bit is always driven, so cut stays 0
      next_l.cut = l.cfg.hiz_early & nq.lsb & l.pend_oe_n & ~dsp;
      // Filter sync follows the first enabled slot; a disabled slot never sets it.
      // The toggle crosses to the system clock and becomes a one-cycle pulse there.
      if (!off_a) begin
         sync_at = sa;
      end else if (!off_b) begin
         sync_at = sb;
      end else begin
         sync_at = ASP_POS_FIRST;
      end
      if (np == sync_at) begin
         next_l.sync_t = ~l.sync_t;
      end
   end

   // The link reset is asserted asynchronously; the bit clock may be stopped during it
   always_ff @(posedge lclk or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         l <= '{
            req_s: 2'h0,
            ack: 1'b0,
            words: '0,
            cfg: '0,
            wq: 1'b0,
            pos: '0,
            flen: ASP_FLEN_RST,
            fpos: ASP_FPOS_RST,
            pend: 1'b0,
            pend_oe_n: 1'b1,
            pend_lsb: 1'b0,
            cut: 1'b0,
            sync_t: 1'b0
         };
      end else begin
         l <= next_l;
      end
   end

   // Falling-edge launch stage for the rising-edge formats
   always_ff @(negedge lclk or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         nq <= '{
            d: 1'b0,
            oe_n: 1'b1,
            lsb: 1'b0
         };
      end else begin
         // Half a bit of setup ahead of the rising edge that samples the bit
         nq <= '{
            d: l.pend,
            oe_n: l.pend_oe_n,
            lsb: l.pend_lsb
         };
      end
   end

   assign dout_o = (l.cfg.fmt == ASP_FMT_DSP) ? l.pend : nq.d;
   assign dout_oe_n_o = (l.cfg.fmt == ASP_FMT_DSP) ? l.pend_oe_n : (nq.oe_n | l.cut);
endmodule
`default_nettype wire

// ---- asp_framing_chk.sv ----
/*
 Port checker for asp_framing: clock gating, sample handshake, filter sync, pin drive.
 Assumes settings are held for several frames, so saturating counters can trust them.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_framing_chk (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Watched ports
   input wire logic first_chan_off_i,
   input wire logic second_chan_off_i,
   input wire logic dout_hiz_i,
   input wire logic sample_valid_i,
   input wire logic sample_ready_o,
   input wire logic filter_sync_o,
   input wire logic clk_master_i,
   input wire logic conv_powered_i,
   input wire logic clk_keep_i,
   input wire logic clk_gen_run_o,
   input wire logic dout_oe_n_o
);
   logic [10:0] quiet_cnt;
   logic [10:0] drive_cnt;
   logic both_off;
   logic gen_want;
   assign both_off = first_chan_off_i & second_chan_off_i;
   assign gen_want = clk_master_i & (conv_powered_i | clk_keep_i);
   // Settings reach the link with the next sample pair; wait about five frames before trusting them
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         quiet_cnt <= '0;
         drive_cnt <= '0;
      end else begin
         quiet_cnt <= !(both_off && dout_hiz_i) ? '0 : quiet_cnt + {10'h0, quiet_cnt != 11'h3E8};
         drive_cnt <= (both_off || dout_hiz_i) ? '0 : drive_cnt + {10'h0, drive_cnt != 11'h3E8};
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   a_gen_run_on: assert property (gen_want |=> clk_gen_run_o)
      else $error("generated clocks not enabled");
   a_gen_run_off: assert property (!gen_want |=> !clk_gen_run_o)
      else $error("generated clocks not stopped");
   a_sync_single: assert property (filter_sync_o |=> !filter_sync_o)
      else $error("filter sync longer than one cycle");
   a_ready_drop: assert property (sample_valid_i && sample_ready_o |=> !sample_ready_o [*3])
      else $error("ready did not drop after a pair");
   a_ready_back: assert property ($fell(sample_ready_o) |-> ##[1:60] sample_ready_o)
      else $error("ready did not return");
   a_both_off_float: assert property (quiet_cnt == 11'h3E8 |-> dout_oe_n_o)
      else $error("pin driven with both channels off");
   a_fill_drive_low: assert property (drive_cnt == 11'h3E8 |-> !dout_oe_n_o)
      else $error("pin released with float option off");
   c_sync: cover property (filter_sync_o);
   c_quiet: cover property (quiet_cnt == 11'h3E8);
   c_drive: cover property (drive_cnt == 11'h3E8);
endmodule
bind asp_framing asp_framing_chk u_chk (.clock_i, .sys_rst_i, .first_chan_off_i,
   .second_chan_off_i, .dout_hiz_i, .sample_valid_i, .sample_ready_o, .filter_sync_o,
   .clk_master_i, .conv_powered_i, .clk_keep_i, .clk_gen_run_o, .dout_oe_n_o);
`default_nettype wire

// ---- asp_host_model.sv ----
/*
 Host side of the audio link: makes bit and word clocks, records the data pin.
 Assumes the word clock is a square wave changing on bit-clock falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_host_model #(
   parameter int FRAME_BCLKS = 64
) (
   // Link
   output logic bclk_o,
   output logic wclk_o,
   input wire logic dout_i,
   input wire logic dout_oe_n_i
);
   logic rbit [0:127];
   logic rfloat [0:127];
   logic fbit [0:127];
   int pos;
   int frames;
   initial begin
      bclk_o = 1'b0;
      wclk_o = 1'b0;
      pos = FRAME_BCLKS - 1;
      frames = 0;
      #7;
      forever #16 bclk_o = ~bclk_o;
   end
   // Index n is bit-clock edge n after the word-clock rise, rising for rbit, falling for fbit
   always @(negedge bclk_o) begin
      fbit[pos + 1] <= dout_i;
      pos <= (pos == FRAME_BCLKS - 1) ? 0 : pos + 1;
      wclk_o <= (pos == FRAME_BCLKS - 1) || (pos + 1 < FRAME_BCLKS / 2);
      frames <= frames + int'(pos == FRAME_BCLKS - 1);
   end
   always @(posedge bclk_o) begin
      rbit[pos + 1] <= dout_i;
      rfloat[pos + 1] <= dout_oe_n_i;
   end
endmodule
`default_nettype wire

// ---- audio_serial_port_framing_tb_top.sv ----
/*
 Testbench for asp_framing: steps through formats and slot settings, reads back frames.
 Assumes a 64 bit-clock frame from asp_host_model and a pair offered every cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module audio_serial_port_framing_tb_top;
   import asp_pkg::*;
   localparam logic [31:0] LEFT_W = 32'hA5C3_96E1;
   localparam logic [31:0] RIGHT_W = 32'h5A3C_1E87;
   logic clock_i, sys_rst_i, chan_swap_i, slot_mode_i, first_chan_off_i, second_chan_off_i;
   logic dout_hiz_i, sample_ready_o, filter_sync_o, clk_master_i, conv_powered_i, clk_keep_i;
   logic clk_gen_run_o, bclk_i, wclk_i, dout_o, dout_oe_n_o, fl;
   asp_fmt_t fmt_i;
   logic [1:0] word_len_i;
   logic [7:0] first_slot_delay_i, second_slot_delay_i;
   int mismatches, n_compared, syncs, s0, sync_pos;
   asp_framing u_dut (.clock_i, .sys_rst_i, .fmt_i, .word_len_i, .first_slot_delay_i,
      .second_slot_delay_i, .chan_swap_i, .slot_mode_i, .first_chan_off_i, .second_chan_off_i,
      .dout_hiz_i, .dout_hiz_early_i(1'b0), .bclk_invert_i(1'b0), .left_sample_i(LEFT_W),
      .right_sample_i(RIGHT_W), .sample_valid_i(1'b1), .sample_ready_o, .filter_sync_o,
      .clk_master_i, .conv_powered_i, .clk_keep_i, .clk_gen_run_o, .bclk_i, .wclk_i, .dout_o,
      .dout_oe_n_o);
   asp_host_model u_host (.bclk_o(bclk_i), .wclk_o(wclk_i), .dout_i(dout_o),
      .dout_oe_n_i(dout_oe_n_o));
   always #5 clock_i = ~clock_i;
   // Sampled mid-cycle, away from the edge that launches the pulse
   always @(negedge clock_i) begin
      if (filter_sync_o === 1'b1) begin
         syncs++;
         sync_pos = u_host.pos;
      end
   end
   task automatic final_report();
      if (mismatches == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_frames(input int n);
      int target;
      target = u_host.frames + n;
      for (int i = 0; i < 400 * n && u_host.frames < target; i++) @(posedge clock_i);
      if (u_host.frames < target) begin
         mismatches++;
         final_report();
      end
   endtask
   function automatic logic [31:0] grab(input int start, input int len, input bit fall);
      logic [31:0] w;
      w = '0;
      for (int i = 0; i < len; i++) w = {w[30:0], fall ? u_host.fbit[start + i] : u_host.rbit[start + i]};
      return w;
   endfunction
   // Positions are bit-clock edges after the word-clock rise, falling ones for DSP; 0 skips the left channel
   task automatic run_case(input asp_fmt_t f, input logic [1:0] wl, input logic [7:0] d1,
         input logic [7:0] d2, input logic sw, input logic sm, input int lpos, input int rpos);
      int len;
      len = (wl == ASP_WL_32) ? 32 : 16 + 4 * wl;
      @(posedge clock_i);
      #1;
      fmt_i = f;
      word_len_i = wl;
      first_slot_delay_i = d1;
      second_slot_delay_i = d2;
      chan_swap_i = sw;
      slot_mode_i = sm;
      wait_frames(5);
      if (lpos > 0) check("left word", grab(lpos, len, f == ASP_FMT_DSP), LEFT_W & ~(32'hFFFF_FFFF << len));
      check("right word", grab(rpos, len, f == ASP_FMT_DSP), RIGHT_W & ~(32'hFFFF_FFFF << len));
   endtask
   initial begin
      {clock_i, chan_swap_i, slot_mode_i, first_chan_off_i, second_chan_off_i, dout_hiz_i} = '0;
      {clk_master_i, conv_powered_i, clk_keep_i, mismatches, n_compared, syncs} = '0;
      {fmt_i, word_len_i, first_slot_delay_i, second_slot_delay_i} = '0;
      sys_rst_i = 1'b1;
      repeat (6) @(posedge clock_i);
      #1;
      sys_rst_i = 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(posedge clock_i);
         #1;
         {clk_master_i, conv_powered_i, clk_keep_i} = 3'(i);
         repeat (2) @(posedge clock_i);
         #1;
         check("clock run", clk_gen_run_o, i[2] & (i[1] | i[0]));
      end
      run_case(ASP_FMT_LJF, ASP_WL_16, 8'h00, 8'h00, 1'b0, 1'b0, 1, 33);
      run_case(ASP_FMT_LJF, ASP_WL_16, 8'h01, 8'h00, 1'b1, 1'b0, 34, 2);
      run_case(ASP_FMT_LJF, ASP_WL_16, 8'h00, 8'h01, 1'b0, 1'b1, 1, 18);
      run_case(ASP_FMT_LJF, ASP_WL_16, 8'h00, 8'h01, 1'b1, 1'b1, 18, 1);
      run_case(ASP_FMT_I2S, ASP_WL_16, 8'h00, 8'h00, 1'b0, 1'b0, 34, 2);
      run_case(ASP_FMT_I2S, ASP_WL_20, 8'h02, 8'h00, 1'b0, 1'b0, 36, 4);
      run_case(ASP_FMT_DSP, ASP_WL_24, 8'h01, 8'h00, 1'b0, 1'b0, 2, 26);
      run_case(ASP_FMT_RJF, ASP_WL_16, 8'h00, 8'h00, 1'b0, 1'b0, 17, 49);
      run_case(ASP_FMT_RJF, ASP_WL_16, 8'h00, 8'h03, 1'b0, 1'b1, 17, 49);
      run_case(ASP_FMT_LJF, ASP_WL_32, 8'h00, 8'h00, 1'b0, 1'b0, 1, 33);
      #1;
      dout_hiz_i = 1'b1;
      first_chan_off_i = 1'b1;
      run_case(ASP_FMT_LJF, ASP_WL_16, 8'h00, 8'h00, 1'b0, 1'b0, 0, 33);
      check("first slot float", u_host.rfloat[1], 32'h1);
      check("sync at second slot", (sync_pos == 32) || (sync_pos == 33), 32'h1);
      s0 = syncs;
      #1;
      second_chan_off_i = 1'b1;
      wait_frames(6);
      fl = 1'b1;
      for (int k = 1; k <= 64; k++) fl = fl & u_host.rfloat[k];
      check("idle float", fl, 32'h1);
      check("filter sync", syncs > s0, 32'h1);
      check("sync at frame start", (sync_pos == 0) || (sync_pos == 1), 32'h1);
      final_report();
   end
endmodule
`default_nettype wire
